// ===== rtl/home_return_cfg.svh
// Purpose: offsets, reset values and limits of the home return sequencer
// Assumes: 32-bit axi4-lite data, one aligned word per register
// Notes: included by bare name
`ifndef HOME_RETURN_CFG_SVH
`define HOME_RETURN_CFG_SVH
`define HR_OFS_CONFIG 8'h00
`define HR_OFS_FEED 8'h04
`define HR_OFS_APPROACH 8'h08
`define HR_OFS_FINAL 8'h0C
`define HR_OFS_CMD 8'h10
`define HR_OFS_STATUS 8'h14
`define HR_OFS_HOME_POS 8'h18
`define HR_CFG_ENABLE 0
`define HR_CFG_MODE_LO 2
`define HR_CFG_MODE_HI 3
`define HR_CFG_DIR 4
`define HR_CMD_START 0
`define HR_RST_CONFIG 16'h0000
`define HR_RST_SPEED 32'h00000001
`define HR_RST_FINAL 32'h00000000
`define HR_SPEED_MIN 32'h00000001
`define HR_SPEED_MAX 32'h0003A980
`define HR_FEED_SCALE 32'h000003E8
`define HR_RESP_OKAY 2'h0
`define HR_RESP_SLVERR 2'h2
`endif

// ===== rtl/home_return_pkg.sv
// Purpose: types shared by the home return sequencer
// Assumes: nothing beyond the cfg header
// Notes: holds types only
package home_return_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FEED, ST_CLEAR, ST_APPROACH, ST_FINAL
    } hr_state_t;
    typedef enum logic [1:0] {
        MODE_ONE = 2'h0, MODE_TWO = 2'h1, MODE_BAD = 2'h2, MODE_THREE = 2'h3
    } hr_mode_t;
    typedef struct packed {
        logic reverse;
        logic [31:0] speed;
    } motion_cmd_t;
endpackage

// ===== rtl/machine_home_return_sequencer.sv
// Purpose: machine home return sequencer with axi4-lite registers
// Assumes: limit and index inputs synchronous to aclk, feedback_pos in command units
// Notes: speed output is in command units per minute; zero when idle
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "home_return_cfg.svh"

// Operation
// - start command launches the return sequence of the configured mode
// - config bits 3:2 decode 00 mode one, 01 mode two, 11 mode three
// - mode one: three steps, limit as slow-down switch, index fixes home
// - mode two: two steps, limit as stop switch, index unused
// - mode three: four steps, limit as slow-down switch plus index pulse
// - start command ignored unless config bit 0 is set
// - config bit 4 selects travel direction, 0 forward, 1 reverse
// - feed speed accepts 1..240000, scaled by 1000 units per minute
// - approach speed accepts 1..240000 units per minute, used after first slow-down
module machine_home_return_sequencer #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // machine inputs
    input wire logic limit_switch_input,
    input wire logic encoder_index_pulse,
    input wire logic [31:0] feedback_pos,
    // motion outputs
    output home_return_pkg::motion_cmd_t motion_cmd,
    output logic position_reached,
    output logic home_set
);
    import home_return_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] config_reg;
    logic [31:0] feed_reg;
    logic [31:0] approach_reg;
    logic [31:0] final_reg;
    logic [31:0] home_pos_reg;
    logic [31:0] start_pos_reg;
    hr_state_t state_reg;
    hr_state_t state_next;
    hr_mode_t mode_reg;
    logic dir_reg;
    logic start_pulse;
    logic wr_fire;
    logic rd_fire;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wval;
    logic [31:0] travel;
    logic [31:0] dist_abs;
    logic travel_done;
    logic mode_ok;
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction
    function automatic logic speed_ok(input logic [31:0] v);
        return (v >= `HR_SPEED_MIN) && (v <= `HR_SPEED_MAX);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write channel: waits for address and data, either may come first
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    assign waddr = s_axi_awaddr;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HR_RESP_OKAY;
        end else begin
            s_axi_awready <= wr_fire;
            s_axi_wready <= wr_fire;
            if (wr_fire) begin
                if (waddr <= `HR_OFS_HOME_POS && waddr[1:0] == 2'h0) begin
                    s_axi_bresp <= `HR_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `HR_RESP_SLVERR;
                end
            end
            // answer only once address and data have been handed over
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // out-of-range speeds are dropped so the profile never sees zero feed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_reg <= `HR_RST_CONFIG;
            feed_reg <= `HR_RST_SPEED;
            approach_reg <= `HR_RST_SPEED;
            final_reg <= `HR_RST_FINAL;
        end else if (wr_fire) begin
            if (waddr == `HR_OFS_CONFIG) begin
                config_reg <= 16'(merge({16'h0000, config_reg}, s_axi_wdata, s_axi_wstrb));
            end else if (waddr == `HR_OFS_FEED) begin
                if (speed_ok(wval)) begin
                    feed_reg <= wval;
                end
            end else if (waddr == `HR_OFS_APPROACH) begin
                if (speed_ok(wval)) begin
                    approach_reg <= wval;
                end
            end else if (waddr == `HR_OFS_FINAL) begin
                final_reg <= merge(final_reg, s_axi_wdata, s_axi_wstrb);
            end
        end
    end
    always_comb begin
        wval = s_axi_wdata;
        if (waddr == `HR_OFS_FEED) begin
            wval = merge(feed_reg, s_axi_wdata, s_axi_wstrb);
        end else if (waddr == `HR_OFS_APPROACH) begin
            wval = merge(approach_reg, s_axi_wdata, s_axi_wstrb);
        end
    end
    // the command word alone starts the sequence, no mode preselect needed
    assign start_pulse = wr_fire && (waddr == `HR_OFS_CMD) && s_axi_wstrb[0] &&
                         s_axi_wdata[`HR_CMD_START];
    ////////////////////////////////////////////////////////////////////////
    // read channel
    assign rd_fire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `HR_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_fire;
            if (rd_fire) begin
                s_axi_rresp <= `HR_RESP_OKAY;
                if (s_axi_araddr == `HR_OFS_CONFIG) begin
                    s_axi_rdata <= {16'h0000, config_reg};
                end else if (s_axi_araddr == `HR_OFS_FEED) begin
                    s_axi_rdata <= feed_reg;
                end else if (s_axi_araddr == `HR_OFS_APPROACH) begin
                    s_axi_rdata <= approach_reg;
                end else if (s_axi_araddr == `HR_OFS_FINAL) begin
                    s_axi_rdata <= final_reg;
                end else if (s_axi_araddr == `HR_OFS_CMD) begin
                    s_axi_rdata <= 32'h00000000;
                end else if (s_axi_araddr == `HR_OFS_STATUS) begin
                    s_axi_rdata <= {24'h000000, 1'b0, position_reached, mode_reg, 1'b0,
                                    state_reg};
                end else if (s_axi_araddr == `HR_OFS_HOME_POS) begin
                    s_axi_rdata <= home_pos_reg;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `HR_RESP_SLVERR;
                end
            end
            // data held since the address was taken; valid waits for that handshake
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // sequencer
    assign mode_ok = config_reg[`HR_CFG_MODE_HI:`HR_CFG_MODE_LO] != MODE_BAD;
    assign travel = (feedback_pos - start_pos_reg) >= 32'h80000000 ?
                    start_pos_reg - feedback_pos : feedback_pos - start_pos_reg;
    // final distance sign is carried by the direction bit, only magnitude counts
    assign dist_abs = final_reg[31] ? (32'h00000000 - final_reg) : final_reg;
    assign travel_done = travel >= dist_abs;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_pulse && config_reg[`HR_CFG_ENABLE] && mode_ok) begin
                    state_next = ST_FEED;
                end
            end
            ST_FEED: begin
                if (limit_switch_input) begin
                    if (mode_reg == MODE_TWO) begin
                        state_next = ST_FINAL;
                    end else if (mode_reg == MODE_THREE) begin
                        state_next = ST_CLEAR;
                    end else begin
                        state_next = ST_APPROACH;
                    end
                end
            end
            ST_CLEAR: begin
                // index only counts once the slow-down dog is passed
                if (!limit_switch_input) begin
                    state_next = ST_APPROACH;
                end
            end
            ST_APPROACH: begin
                if (encoder_index_pulse) begin
                    state_next = ST_FINAL;
                end
            end
            ST_FINAL: begin
                if (travel_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= MODE_ONE;
            dir_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && state_next == ST_FEED) begin
            mode_reg <= hr_mode_t'(config_reg[`HR_CFG_MODE_HI:`HR_CFG_MODE_LO]);
            dir_reg <= config_reg[`HR_CFG_DIR];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_pos_reg <= 32'h00000000;
        end else if (state_next == ST_FINAL && state_reg != ST_FINAL) begin
            start_pos_reg <= feedback_pos;
        end
    end

    // speed follows the next state so it lines up with state_reg
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            motion_cmd <= '0;
        end else begin
            if (state_reg == ST_IDLE && state_next == ST_FEED) begin
                motion_cmd.reverse <= config_reg[`HR_CFG_DIR];
            end
            if (state_next == ST_FEED) begin
                motion_cmd.speed <= 32'(feed_reg * `HR_FEED_SCALE);
            end else if (state_next == ST_IDLE) begin
                motion_cmd.speed <= 32'h00000000;
            end else begin
                motion_cmd.speed <= approach_reg;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            position_reached <= 1'b0;
            home_set <= 1'b0;
            home_pos_reg <= 32'h00000000;
        end else begin
            home_set <= 1'b0;
            if (state_reg == ST_FINAL && travel_done) begin
                position_reached <= 1'b1;
                home_set <= 1'b1;
                home_pos_reg <= feedback_pos;
            end else if (state_next == ST_FEED) begin
                position_reached <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_launch;
        state_reg == ST_IDLE && start_pulse && config_reg[`HR_CFG_ENABLE] && mode_ok;
    endsequence
    sequence s_hit_limit(hr_mode_t m);
        state_reg == ST_FEED && limit_switch_input && mode_reg == m;
    endsequence

    a_cmd_launch: assert property (@(posedge aclk) disable iff (!aresetn)
        s_launch |=> state_reg == ST_FEED && !position_reached) else $error("start lost");
    a_bad_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ST_IDLE && start_pulse && !mode_ok |=> state_reg == ST_IDLE)
        else $error("bad mode started");
    a_mode_one: assert property (@(posedge aclk) disable iff (!aresetn)
        s_hit_limit(MODE_ONE) |=> state_reg == ST_APPROACH ##0
        motion_cmd.speed == $past(approach_reg)) else $error("mode one step wrong");
    a_mode_two: assert property (@(posedge aclk) disable iff (!aresetn)
        s_hit_limit(MODE_TWO) |=> state_reg == ST_FINAL ##0 start_pos_reg == $past(feedback_pos))
        else $error("mode two step wrong");
    a_mode_three: assert property (@(posedge aclk) disable iff (!aresetn)
        s_hit_limit(MODE_THREE) |=> state_reg == ST_CLEAR) else $error("mode three step wrong");
    a_disabled_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ST_IDLE && start_pulse && !config_reg[`HR_CFG_ENABLE] |=>
        state_reg == ST_IDLE && motion_cmd.speed == 32'h00000000) else $error("disabled start");
    a_direction: assert property (@(posedge aclk) disable iff (!aresetn)
        s_launch |=> motion_cmd.reverse == $past(config_reg[`HR_CFG_DIR]))
        else $error("direction wrong");
    a_feed_speed: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ST_FEED && $stable(feed_reg) |->
        motion_cmd.speed == 32'(feed_reg * `HR_FEED_SCALE)) else $error("feed speed wrong");
    a_speed_range: assert property (@(posedge aclk) disable iff (!aresetn)
        speed_ok(approach_reg) && speed_ok(feed_reg)) else $error("speed out of range");
    a_final_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ST_FINAL && travel_done |=> state_reg == ST_IDLE && home_set ##1
        motion_cmd.speed == 32'h00000000 || state_reg != ST_IDLE) else $error("no stop");
    a_done_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(position_reached) |-> $past(state_reg) == ST_FINAL && state_reg == ST_IDLE)
        else $error("complete out of place");
endmodule

// ===== verif/machine_model.sv
// Purpose: stand-in machine axis driven by the home return sequencer
// Assumes: one command unit of travel per clock while speed is nonzero
// Notes: small limit band and index spacing keep each return short
`timescale 1ns/1ps
module machine_model #(
    parameter int LIM_LO = 8,
    parameter int LIM_HI = 12
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // commanded motion
    input home_return_pkg::motion_cmd_t motion_cmd,
    // machine feedback
    output logic limit_switch_input,
    output logic encoder_index_pulse,
    output logic [31:0] feedback_pos
);
    import home_return_pkg::*;
    logic [31:0] mag;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            feedback_pos <= 32'h0;
        end else if (motion_cmd.speed != 32'h0) begin
            feedback_pos <= motion_cmd.reverse ? feedback_pos - 32'h1 : feedback_pos + 32'h1;
        end
    end
    // distance from start, so the dog sits the same way in both directions
    assign mag = feedback_pos[31] ? 32'h0 - feedback_pos : feedback_pos;
    assign limit_switch_input = (mag >= 32'(LIM_LO)) && (mag < 32'(LIM_HI));
    // index every 4 units; one falls inside the dog band on purpose
    assign encoder_index_pulse = (mag[1:0] == 2'h0) && (mag != 32'h0);
endmodule

// ===== verif/tb_machine_home_return_sequencer.sv
// Purpose: self-checking bench of the home return sequencer
// Assumes: machine_model moves one unit per clock
// Notes: every scenario starts from its own reset
`timescale 1ns/1ps
`include "home_return_cfg.svh"
module tb_machine_home_return_sequencer;
    import home_return_pkg::*;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, feedback_pos;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic limit_switch_input, encoder_index_pulse, position_reached, home_set;
    motion_cmd_t motion_cmd;
    int n_fail = 0;
    int compares = 0;
    // mode codes and expected home distance: index at 12, dog start 8, index at 16, final 3
    logic [1:0] modes [3] = '{2'h0, 2'h1, 2'h3};
    logic [31:0] homes [3] = '{32'h0000000F, 32'h0000000B, 32'h00000013};
    ////////////////////////////////////////////////////////////////////////////////
    machine_home_return_sequencer #(.ADDR_W(8)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .limit_switch_input(limit_switch_input), .encoder_index_pulse(encoder_index_pulse),
        .feedback_pos(feedback_pos), .motion_cmd(motion_cmd),
        .position_reached(position_reached), .home_set(home_set)
    );
    machine_model mach (
        .aclk(aclk), .aresetn(aresetn), .motion_cmd(motion_cmd),
        .limit_switch_input(limit_switch_input), .encoder_index_pulse(encoder_index_pulse),
        .feedback_pos(feedback_pos)
    );
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic timeout(input string what);
        n_fail++;
        $display("Error %s expected answer seen none", what);
        end_sim();
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // sentinel 3 never comes back from this slave
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (r === 2'h3 && n < 20) begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (r === 2'h3) timeout("write response");
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (s_axi_rvalid !== 1'b1 && n < 20) begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (s_axi_rvalid !== 1'b1) timeout(what);
        s_axi_rready <= 1'b0;
        check(what, exp, s_axi_rdata);
        check(what, 32'(er), 32'(s_axi_rresp));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        logic [1:0] r;
        do_reset();
        rd_chk("config reset", `HR_OFS_CONFIG, 32'h0, `HR_RESP_OKAY);
        rd_chk("feed reset", `HR_OFS_FEED, 32'h1, `HR_RESP_OKAY);
        rd_chk("approach reset", `HR_OFS_APPROACH, 32'h1, `HR_RESP_OKAY);
        rd_chk("final reset", `HR_OFS_FINAL, 32'h0, `HR_RESP_OKAY);
        axi_wr(`HR_OFS_FEED, 32'h0, r);
        axi_wr(`HR_OFS_APPROACH, 32'h0003A981, r);
        rd_chk("feed zero", `HR_OFS_FEED, 32'h1, `HR_RESP_OKAY);
        rd_chk("approach over", `HR_OFS_APPROACH, 32'h1, `HR_RESP_OKAY);
        axi_wr(`HR_OFS_FEED, `HR_SPEED_MAX, r);
        axi_wr(`HR_OFS_APPROACH, `HR_SPEED_MAX, r);
        rd_chk("feed max", `HR_OFS_FEED, `HR_SPEED_MAX, `HR_RESP_OKAY);
        rd_chk("approach max", `HR_OFS_APPROACH, `HR_SPEED_MAX, `HR_RESP_OKAY);
        axi_wr(`HR_OFS_CONFIG, 32'hFFFFFFFF, r);
        rd_chk("config width", `HR_OFS_CONFIG, 32'h0000FFFF, `HR_RESP_OKAY);
        axi_wr(`HR_OFS_STATUS, 32'hFFFFFFFF, r);
        check("status write resp", 32'(`HR_RESP_OKAY), 32'(r));
        rd_chk("status idle", `HR_OFS_STATUS, 32'h0, `HR_RESP_OKAY);
        axi_wr(8'h40, 32'h0, r);
        check("unmapped write resp", 32'(`HR_RESP_SLVERR), 32'(r));
        rd_chk("unmapped read", 8'h40, 32'h0, `HR_RESP_SLVERR);
        $display("test_regs done");
    endtask
    // disabled function, then the unused mode code while enabled
    task automatic test_ignored();
        logic [1:0] r;
        logic [15:0] cfgs [2] = '{16'h000C, 16'h0009};
        foreach (cfgs[i]) begin
            do_reset();
            axi_wr(`HR_OFS_CONFIG, {16'h0, cfgs[i]}, r);
            axi_wr(`HR_OFS_CMD, 32'h1, r);
            check("ignored start speed", 32'h0, motion_cmd.speed);
            rd_chk("ignored start status", `HR_OFS_STATUS, 32'h0, `HR_RESP_OKAY);
        end
        $display("test_ignored done");
    endtask
    task automatic test_mode(input logic [1:0] mode, input logic dir, input logic [31:0] hmag);
        logic [1:0] r;
        logic [31:0] mag;
        int nbad;
        int n;
        nbad = 0;
        n = 0;
        do_reset();
        axi_wr(`HR_OFS_CONFIG, {27'h0, dir, mode, 2'h1}, r);
        axi_wr(`HR_OFS_FEED, 32'h5, r);
        axi_wr(`HR_OFS_APPROACH, 32'h7, r);
        axi_wr(`HR_OFS_FINAL, 32'h3, r);
        // start alone, no mode selection first
        axi_wr(`HR_OFS_CMD, 32'h1, r);
        while (home_set !== 1'b1 && n < 100) begin
            @(negedge aclk);
            n++;
            mag = feedback_pos[31] ? 32'h0 - feedback_pos : feedback_pos;
            if (motion_cmd.speed !== 32'h0 && motion_cmd.reverse !== dir) nbad++;
            if (motion_cmd.speed !== 32'h0 && motion_cmd.speed !==
                (mag <= 32'h8 ? 32'h5 * `HR_FEED_SCALE : 32'h7)) nbad++;
        end
        if (home_set !== 1'b1) timeout("home point pulse");
        check("speed profile", 32'h0, 32'(nbad));
        check("position reached", 32'h1, {31'h0, position_reached});
        check("stopped speed", 32'h0, motion_cmd.speed);
        @(negedge aclk);
        check("home pulse width", 32'h0, {31'h0, home_set});
        rd_chk("home point", `HR_OFS_HOME_POS, dir ? 32'h0 - hmag : hmag,
               `HR_RESP_OKAY);
        rd_chk("status done", `HR_OFS_STATUS, {25'h0, 1'b1, mode, 4'h0},
               `HR_RESP_OKAY);
        $display("test_mode mode %b dir %b done", mode, dir);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        test_regs();
        test_ignored();
        for (int m = 0; m < 3; m++) begin
            test_mode(modes[m], 1'b0, homes[m]);
            test_mode(modes[m], 1'b1, homes[m]);
        end
        end_sim();
    end
endmodule
